// ==== rtl/smc_consts.vh ====
// Offsets, fields, reset values and timing counts of the clock select block
`ifndef SMC_CONSTS_VH
`define SMC_CONSTS_VH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define SMC_OFS_SLOW_CFG    32'h0ffffe50
`define SMC_OFS_MAIN_OSC    32'h0ffffe54
`define SMC_OFS_STATUS      32'h0ffffe58
`define SMC_OFS_IRQ_ENABLE  32'h0ffffe5c
`define SMC_OFS_IRQ_DISABLE 32'h0ffffe60
`define SMC_OFS_IRQ_MASK    32'h0ffffe64

// ----------------------------------------------------------------
// Slow clock config fields
// ----------------------------------------------------------------
`define SMC_SLOW_RC_EN      0
`define SMC_SLOW_XT_EN      1
`define SMC_SLOW_XT_BYP     2
`define SMC_SLOW_SEL        3
`define SMC_SLOW_CFG_RESET  4'h1

// ----------------------------------------------------------------
// Main oscillator register fields
// ----------------------------------------------------------------
`define SMC_MAIN_XT_EN      0
`define SMC_MAIN_XT_BYP     1
`define SMC_MAIN_RC_EN      3
`define SMC_MAIN_CNT_LO     8
`define SMC_MAIN_CNT_HI     15
`define SMC_MAIN_SEL        24

// ----------------------------------------------------------------
// Status fields
// ----------------------------------------------------------------
`define SMC_ST_XT_STABLE    0
`define SMC_ST_RC_STABLE    1
`define SMC_ST_SEL_DONE     2

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define SMC_XT_PRESCALE     8
`define SMC_RC_STARTUP_NS   10000
`define SMC_CLK_PERIOD_NS   10
`define SMC_RC_STARTUP_CYC  ((`SMC_RC_STARTUP_NS + `SMC_CLK_PERIOD_NS - 1) / `SMC_CLK_PERIOD_NS)
`define SMC_SW_SETTLE       4

`endif

// ==== rtl/smc_edge_count.v ====
// Slow clock edge divider and start-up down-counter
`timescale 1ns/1ns
module smc_edge_count #(
    parameter PRESCALE = 8,
    parameter WIDTH    = 8
) (
    // Clock and reset
    input  wire             core_clk,
    input  wire             rst_b,
    // Control
    input  wire             slow_tick,
    input  wire             load,
    input  wire [WIDTH-1:0] load_val,
    input  wire             run,
    // Result
    output reg              done_q
);

    reg [WIDTH-1:0] cnt_q;
    reg [3:0]       pre_q;
    reg             active_q;

    wire pre_wrap = slow_tick && (pre_q == PRESCALE[3:0] - 4'h1);

    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt_q    <= {WIDTH{1'b0}};
            pre_q    <= 4'h0;
            active_q <= 1'b0;
            done_q   <= 1'b0;
        end else if (!run) begin
            active_q <= 1'b0;
            done_q   <= 1'b0;
        end else if (load) begin
            cnt_q    <= load_val;
            pre_q    <= 4'h0;
            active_q <= 1'b1;
            done_q   <= 1'b0;
        end else if (active_q) begin
            if (cnt_q == {WIDTH{1'b0}}) begin
                active_q <= 1'b0;
                done_q   <= 1'b1;
            end else if (slow_tick) begin
                pre_q <= pre_wrap ? 4'h0 : pre_q + 4'h1;
                if (pre_wrap)
                    cnt_q <= cnt_q - {{(WIDTH-1){1'b0}}, 1'b1};
            end
        end
    end

endmodule // smc_edge_count

// ==== rtl/smc_clock_select.v ====
// Slow and main clock source selection with status and interrupt
//
// Contract
// - Slow select 0 picks RC, 1 crystal
// - Slow bypass takes external clock from pin
// - Slow RC enable bit drives RC oscillator
// - Slow crystal enable drives crystal oscillator
// - Backup reset gives RC on, rest off
// - Slow config held while backup supply present
// - Main bypass accepts external clock on pin
// - Reset: main RC on, crystal off, RC selected
// - Select without stable forced back to 0 unless the same write sets bypass
// - Clearing main RC enable clears RC stable
// - RC stable raises interrupt when enabled
// - Clearing crystal enable clears crystal stable
// - Enable write loads count, counts slow/8
// - Crystal stable raises interrupt when masked in
// - Glitch-free main switch, done flag reported
// - Wait mode selects main RC
`timescale 1ns/1ns
`include "smc_consts.vh"
module smc_clock_select #(
    parameter CNT_W      = 8,
    parameter RC_STARTUP = `SMC_RC_STARTUP_CYC
) (
    // Clocks and resets
    input  wire        core_clk,
    input  wire        rst_b,
    input  wire        backup_rst_b,
    // Register port
    input  wire [31:0] reg_addr,
    input  wire [31:0] reg_wdata,
    input  wire        reg_wr,
    input  wire        reg_rd,
    output reg  [31:0] reg_rdata,
    // Oscillator pins and strobes
    input  wire        slow_tick,
    input  wire        slow_xtal_input_pin,
    input  wire        main_xtal_input_pin,
    input  wire        wait_mode,
    // Oscillator controls
    output wire        slow_rc_on,
    output wire        slow_xtal_on,
    output wire        slow_use_pin,
    output wire        slow_use_xtal,
    output wire        main_rc_on,
    output wire        main_xtal_on,
    output wire        main_use_pin,
    output wire        main_use_xtal,
    // Status
    output wire        xtal_pin_level,
    output wire        irq
);

    // ----------------------------------------------------------------
    // Slow clock configuration, backup domain
    // ----------------------------------------------------------------
    reg  [3:0] slow_cfg_q;
    wire       wr_slow = reg_wr && (reg_addr == `SMC_OFS_SLOW_CFG);
    wire       wr_main = reg_wr && (reg_addr == `SMC_OFS_MAIN_OSC);
    wire       wr_ier  = reg_wr && (reg_addr == `SMC_OFS_IRQ_ENABLE);
    wire       wr_idr  = reg_wr && (reg_addr == `SMC_OFS_IRQ_DISABLE);

    // Own reset: main resets must not disturb it
    always @(posedge core_clk or negedge backup_rst_b) begin
        if (!backup_rst_b)
            slow_cfg_q <= `SMC_SLOW_CFG_RESET;
        else if (wr_slow)
            slow_cfg_q <= reg_wdata[3:0];
    end

    assign slow_rc_on    = slow_cfg_q[`SMC_SLOW_RC_EN];
    assign slow_xtal_on  = slow_cfg_q[`SMC_SLOW_XT_EN];
    assign slow_use_pin  = slow_cfg_q[`SMC_SLOW_XT_BYP];
    assign slow_use_xtal = slow_cfg_q[`SMC_SLOW_SEL];
    // Bypass hands the slow crystal pin through; main crystal pin otherwise
    assign xtal_pin_level = slow_use_pin ? slow_xtal_input_pin : main_xtal_input_pin;

    // ----------------------------------------------------------------
    // Main oscillator register
    // ----------------------------------------------------------------
    reg             main_rc_en_q;
    reg             main_xt_en_q;
    reg             main_xt_byp_q;
    reg             main_sel_q;
    reg [CNT_W-1:0] main_cnt_q;
    wire            xt_stable;
    wire            sel_req = reg_wdata[`SMC_MAIN_SEL];

    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            main_rc_en_q  <= 1'b1;
            main_xt_en_q  <= 1'b0;
            main_xt_byp_q <= 1'b0;
            main_sel_q    <= 1'b0;
            main_cnt_q    <= {CNT_W{1'b0}};
        end else begin
            if (wr_main) begin
                main_rc_en_q  <= reg_wdata[`SMC_MAIN_RC_EN];
                main_xt_en_q  <= reg_wdata[`SMC_MAIN_XT_EN];
                main_xt_byp_q <= reg_wdata[`SMC_MAIN_XT_BYP];
                main_cnt_q    <= reg_wdata[`SMC_MAIN_CNT_HI:`SMC_MAIN_CNT_LO];
                // Unstable crystal cannot be chosen
                // Stable flag lags a disable by a cycle, so the enable is checked too
                main_sel_q    <= sel_req && ((xt_stable && main_xt_en_q) || reg_wdata[`SMC_MAIN_XT_BYP]);
            end else if (wait_mode) begin
                main_sel_q    <= 1'b0;
            end
        end
    end

    assign main_rc_on   = main_rc_en_q;
    assign main_xtal_on = main_xt_en_q && !main_xt_byp_q;
    assign main_use_pin = main_xt_byp_q;

    // ----------------------------------------------------------------
    // Crystal start-up counter
    // ----------------------------------------------------------------
    wire xt_load = wr_main && reg_wdata[`SMC_MAIN_XT_EN] && !main_xt_en_q;

    smc_edge_count #(
        .PRESCALE (`SMC_XT_PRESCALE),
        .WIDTH    (CNT_W)
    ) u_xt_count (
        .core_clk (core_clk),
        .rst_b    (rst_b),
        .slow_tick(slow_tick),
        .load     (xt_load),
        .load_val (reg_wdata[`SMC_MAIN_CNT_HI:`SMC_MAIN_CNT_LO]),
        .run      (main_xt_en_q || xt_load),
        .done_q   (xt_stable)
    );

    // ----------------------------------------------------------------
    // RC start-up timer
    // ----------------------------------------------------------------
    reg [15:0] rc_cnt_q;
    reg        rc_stable_q;

    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            rc_cnt_q    <= 16'h0;
            rc_stable_q <= 1'b0;
        end else if (!main_rc_en_q) begin
            rc_cnt_q    <= 16'h0;
            rc_stable_q <= 1'b0;
        end else if (rc_cnt_q == RC_STARTUP[15:0] - 16'h1) begin
            rc_stable_q <= 1'b1;
        end else begin
            rc_cnt_q <= rc_cnt_q + 16'h1;
        end
    end

    // ----------------------------------------------------------------
    // Glitch-free switch: gate old source, settle, enable new
    // ----------------------------------------------------------------
    reg       use_xt_q;
    reg       sel_done_q;
    reg [2:0] sw_cnt_q;

    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            use_xt_q   <= 1'b0;
            sel_done_q <= 1'b1;
            sw_cnt_q   <= 3'h0;
        end else if (main_sel_q != use_xt_q) begin
            sel_done_q <= 1'b0;
            if (sw_cnt_q == `SMC_SW_SETTLE - 1) begin
                use_xt_q   <= main_sel_q;
                sel_done_q <= 1'b1;
                sw_cnt_q   <= 3'h0;
            end else begin
                sw_cnt_q <= sw_cnt_q + 3'h1;
            end
        end else begin
            sw_cnt_q <= 3'h0;
        end
    end

    assign main_use_xtal = use_xt_q && (sw_cnt_q == 3'h0);

    // ----------------------------------------------------------------
    // Interrupt mask and output
    // ----------------------------------------------------------------
    reg  [2:0] irq_mask_q;
    wire [2:0] status = {sel_done_q, rc_stable_q, xt_stable};

    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b)
            irq_mask_q <= 3'h0;
        else if (wr_ier)
            irq_mask_q <= irq_mask_q | reg_wdata[2:0];
        else if (wr_idr)
            irq_mask_q <= irq_mask_q & ~reg_wdata[2:0];
    end

    // Level interrupt, follows status so no clear needed
    assign irq = |(status & irq_mask_q);

    // ----------------------------------------------------------------
    // Read port
    // ----------------------------------------------------------------
    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            reg_rdata <= 32'h0;
        end else if (reg_rd) begin
            case (reg_addr)
                `SMC_OFS_SLOW_CFG:   reg_rdata <= {28'h0, slow_cfg_q};
                `SMC_OFS_MAIN_OSC:   reg_rdata <= {7'h0, main_sel_q, 8'h0, main_cnt_q, 4'h0,
                                                   main_rc_en_q, 1'b0, main_xt_byp_q, main_xt_en_q};
                `SMC_OFS_STATUS:     reg_rdata <= {29'h0, status};
                `SMC_OFS_IRQ_MASK:   reg_rdata <= {29'h0, irq_mask_q};
                default:             reg_rdata <= 32'h0;
            endcase
        end else begin
            reg_rdata <= 32'h0;
        end
    end

endmodule // smc_clock_select

// ==== tb/smc_osc_model.sv ====
// External crystal and clock source model for the clock select block
`timescale 1ns/1ns
module smc_osc_model #(
    parameter TICK_DIV = 4
) (
    // Clock
    input  wire core_clk,
    // Oscillator outputs
    output reg  slow_tick,
    output reg  slow_xtal_input_pin,
    output reg  main_xtal_input_pin
);
    // ------------------------------------------------
    // Sources
    // ------------------------------------------------
    // Crystals run free, so the pins toggle even when unused
    integer div_q;
    initial begin
        div_q = 0;
        slow_tick = 1'b0;
        slow_xtal_input_pin = 1'b0;
        main_xtal_input_pin = 1'b0;
    end
    always @(posedge core_clk) begin
        div_q <= (div_q == TICK_DIV - 1) ? 0 : div_q + 1;
        slow_tick <= (div_q == TICK_DIV - 1);
        if (div_q == 0) slow_xtal_input_pin <= ~slow_xtal_input_pin;
        main_xtal_input_pin <= ~main_xtal_input_pin;
    end
endmodule // smc_osc_model

// ==== tb/smc_clock_select_props.sv ====
// Port assertions for the clock select block
`timescale 1ns/1ns
`include "smc_consts.vh"
module smc_clock_select_props (
    // Clock, resets and bus
    input wire        core_clk,
    input wire        rst_b,
    input wire        backup_rst_b,
    input wire [31:0] reg_addr,
    input wire [31:0] reg_wdata,
    input wire        reg_wr,
    input wire        reg_rd,
    input wire [31:0] reg_rdata,
    // Pins and controls
    input wire        slow_xtal_input_pin,
    input wire        main_xtal_input_pin,
    input wire        wait_mode,
    input wire        slow_rc_on,
    input wire        slow_xtal_on,
    input wire        slow_use_pin,
    input wire        slow_use_xtal,
    input wire        main_rc_on,
    input wire        main_xtal_on,
    input wire        main_use_pin,
    input wire        main_use_xtal,
    input wire        xtal_pin_level
);
    // ------------------------------------------------
    // Properties
    // ------------------------------------------------
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    wire [3:0] slow_v = {slow_use_xtal, slow_use_pin, slow_xtal_on, slow_rc_on};
    sequence s_slow_wr; reg_wr && reg_addr == `SMC_OFS_SLOW_CFG; endsequence
    sequence s_slow_rd; reg_rd && reg_addr == `SMC_OFS_SLOW_CFG; endsequence
    sequence s_main_wr; reg_wr && reg_addr == `SMC_OFS_MAIN_OSC; endsequence
    slow_write_a: assert property (s_slow_wr ##0 backup_rst_b |=> slow_v == $past(reg_wdata[3:0]))
        else $error("slow config outputs differ from write");
    slow_read_a: assert property (s_slow_rd |=> reg_rdata == {28'h0, $past(slow_v)})
        else $error("slow config readback wrong");
    slow_reset_a: assert property (!backup_rst_b |-> slow_v == 4'h1)
        else $error("slow config not at backup reset value");
    pin_level_a: assert property (xtal_pin_level == (slow_use_pin ? slow_xtal_input_pin : main_xtal_input_pin))
        else $error("pin level source wrong");
    wait_main_a: assert property ($rose(wait_mode) |-> ##[1:8] !main_use_xtal)
        else $error("wait mode kept crystal");
    sel_refuse_a: assert property (s_main_wr ##0 reg_wdata[24] && reg_wdata[1:0] == 2'h0 && !main_xtal_on
        && !main_use_pin && !main_use_xtal |=> !main_use_xtal [*8]) else $error("unstable crystal selected");
    main_reset_a: assert property ($rose(rst_b) |-> main_rc_on && !main_xtal_on && !main_use_xtal)
        else $error("main clock not on RC after reset");
    main_rc_a: assert property (s_main_wr |=> main_rc_on == $past(reg_wdata[3]))
        else $error("main rc enable wrong");
    main_byp_a: assert property (s_main_wr |=> main_use_pin == $past(reg_wdata[1])
        && main_xtal_on == ($past(reg_wdata[0]) && !$past(reg_wdata[1]))) else $error("main bypass wrong");
endmodule // smc_clock_select_props
bind smc_clock_select smc_clock_select_props i_smc_clock_select_props (.core_clk, .rst_b, .backup_rst_b,
    .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .slow_xtal_input_pin, .main_xtal_input_pin, .wait_mode,
    .slow_rc_on, .slow_xtal_on, .slow_use_pin, .slow_use_xtal, .main_rc_on, .main_xtal_on, .main_use_pin,
    .main_use_xtal, .xtal_pin_level);

// ==== tb/smc_clock_select_bench.sv ====
// Register level testbench for the clock select block
`timescale 1ns/1ns
`include "smc_consts.vh"
module smc_clock_select_bench;
    // ------------------------------------------------
    // Signals and tasks
    // ------------------------------------------------
    localparam [31:0] A_SL = `SMC_OFS_SLOW_CFG, A_MN = `SMC_OFS_MAIN_OSC, A_ST = `SMC_OFS_STATUS;
    localparam [31:0] A_IE = `SMC_OFS_IRQ_ENABLE, A_ID = `SMC_OFS_IRQ_DISABLE, A_IM = `SMC_OFS_IRQ_MASK;
    reg         core_clk, rst_b, backup_rst_b, reg_wr, reg_rd, wait_mode;
    reg  [31:0] reg_addr, reg_wdata, d;
    wire [31:0] reg_rdata;
    wire        slow_tick, slow_xtal_input_pin, main_xtal_input_pin, slow_rc_on, slow_xtal_on, slow_use_pin;
    wire        slow_use_xtal, main_rc_on, main_xtal_on, main_use_pin, main_use_xtal, xtal_pin_level, irq;
    integer     n_errors, n_tests;
    // Short start-up count keeps the run brief
    smc_clock_select #(.CNT_W(8), .RC_STARTUP(4)) i_smc_clock_select (.core_clk, .rst_b, .backup_rst_b,
        .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .slow_tick, .slow_xtal_input_pin,
        .main_xtal_input_pin, .wait_mode, .slow_rc_on, .slow_xtal_on, .slow_use_pin, .slow_use_xtal, .main_rc_on,
        .main_xtal_on, .main_use_pin, .main_use_xtal, .xtal_pin_level, .irq);
    smc_osc_model #(.TICK_DIV(4)) i_smc_osc_model (.core_clk, .slow_tick, .slow_xtal_input_pin, .main_xtal_input_pin);
    task conclude;
        $display("tests %0d errors %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task chk(input string name, input [31:0] exp, input [31:0] got);
        n_tests = n_tests + 1;
        if (got !== exp) begin
            n_errors = n_errors + 1;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask
    task wr(input [31:0] a, input [31:0] v);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        // Let the written register settle before anyone looks at its outputs
        #1;
    endtask
    task rd(input [31:0] a);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask
    task rdc(input string name, input [31:0] a, input [31:0] msk, input [31:0] exp);
        rd(a);
        chk(name, exp, d & msk);
    endtask
    task cyc(input integer n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    task poll(input integer b);
        integer i;
        d = 32'h0;
        for (i = 0; i < 100 && d[b] !== 1'b1; i = i + 1) rd(A_ST);
        chk("status_poll", 32'h1, {31'h0, d[b]});
        if (d[b] !== 1'b1) conclude;
    endtask
    task pins(input sel_slow);
        integer i;
        for (i = 0; i < 6; i = i + 1) begin
            cyc(1);
            chk("pin_level", sel_slow ? slow_xtal_input_pin : main_xtal_input_pin, xtal_pin_level);
        end
    endtask
    // ------------------------------------------------
    // Sequence
    // ------------------------------------------------
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    initial begin
        {rst_b, backup_rst_b, reg_wr, reg_rd, wait_mode} = 5'h0;
        {reg_addr, reg_wdata, n_errors, n_tests} = 0;
        repeat (2) @(posedge core_clk);
        rst_b <= 1'b1;
        backup_rst_b <= 1'b1;
        rdc("slow_cfg", A_SL, 32'hffffffff, 32'h1);
        rdc("main_osc", A_MN, 32'h0100000b, 32'h8);
        chk("main_use_xtal", 32'h0, main_use_xtal);
        poll(`SMC_ST_RC_STABLE);
        wr(A_SL, 32'hffffff03);
        rdc("slow_cfg", A_SL, 32'hffffffff, 32'h3);
        cyc(20);
        wr(A_SL, 32'hb);
        cyc(20);
        wr(A_SL, 32'ha);
        chk("slow_src", 32'h2, {slow_use_xtal, slow_rc_on});
        @(posedge core_clk) rst_b <= 1'b0;
        @(posedge core_clk) rst_b <= 1'b1;
        rdc("slow_kept", A_SL, 32'hffffffff, 32'ha);
        wr(A_SL, 32'hc);
        chk("slow_pin", 32'h1, slow_use_pin);
        pins(1'b1);
        wr(A_SL, 32'hd);
        cyc(20);
        wr(A_SL, 32'h5);
        cyc(20);
        wr(A_SL, 32'h1);
        chk("slow_src", 32'h1, {slow_use_xtal, slow_rc_on});
        wr(A_SL, 32'h6);
        @(posedge core_clk) backup_rst_b <= 1'b0;
        @(posedge core_clk) backup_rst_b <= 1'b1;
        rdc("slow_reset", A_SL, 32'hffffffff, 32'h1);
        wr(A_MN, 32'h01000008);
        cyc(8);
        rdc("sel_refused", A_MN, 32'h01000000, 32'h0);
        wr(A_MN, 32'h00000209);
        rdc("xt_stable", A_ST, 32'h1, 32'h0);
        cyc(30);
        rdc("xt_stable", A_ST, 32'h1, 32'h0);
        poll(`SMC_ST_XT_STABLE);
        wr(A_IE, 32'h1);
        chk("irq", 32'h1, irq);
        rdc("irq_mask", A_IM, 32'h7, 32'h1);
        wr(A_ID, 32'h1);
        chk("irq", 32'h0, irq);
        wr(A_MN, 32'h01000209);
        cyc(8);
        chk("main_use_xtal", 32'h1, main_use_xtal);
        rdc("sel_done", A_ST, 32'h4, 32'h4);
        wr(A_MN, 32'h01000201);
        cyc(2);
        rdc("rc_stable", A_ST, 32'h2, 32'h0);
        wr(A_IE, 32'h2);
        chk("irq", 32'h0, irq);
        wr(A_MN, 32'h01000209);
        poll(`SMC_ST_RC_STABLE);
        chk("irq", 32'h1, irq);
        wr(A_ID, 32'h2);
        @(posedge core_clk) wait_mode <= 1'b1;
        cyc(8);
        chk("wait_sel", 32'h0, main_use_xtal);
        rdc("wait_sel", A_MN, 32'h01000000, 32'h0);
        @(posedge core_clk) wait_mode <= 1'b0;
        wr(A_MN, 32'h8);
        cyc(2);
        rdc("xt_stable", A_ST, 32'h1, 32'h0);
        wr(A_MN, 32'h0100000a);
        cyc(8);
        chk("main_byp", 32'h3, {main_use_pin, main_use_xtal});
        pins(1'b0);
        rdc("unmapped", 32'h0ffffe70, 32'hffffffff, 32'h0);
        conclude;
    end
endmodule // smc_clock_select_bench
